// >>> design/lcc_pkg.sv
/*
 * Constants shared by the graphic LCD command interpreter: command codes,
 * field positions, attribute encodings, combine modes and reset values.
 * Assumes an 8-bit host port and a 16-bit display RAM address space.
 */
package lcc_pkg;

    // command groups (upper bits) and fixed codes
    localparam logic [7:0] CMD_SET_ADDR_PTR = 8'h24;
    localparam logic [7:0] CMD_TEXT_AREA    = 8'h41;
    localparam logic [7:0] CMD_GRAPH_AREA   = 8'h43;
    localparam logic [3:0] GRP_MODE_SET     = 4'h8;
    localparam logic [3:0] GRP_DISP_MODE    = 4'h9;
    localparam logic [4:0] GRP_CURSOR_PAT   = 5'h14;
    localparam logic [7:0] CMD_AUTO_WRITE   = 8'hB0;
    localparam logic [7:0] CMD_AUTO_READ    = 8'hB1;
    localparam logic [7:0] CMD_AUTO_RESET   = 8'hB2;
    localparam logic [4:0] GRP_SINGLE_DATA  = 5'h18;
    localparam logic [7:0] CMD_PEEK         = 8'hE0;
    localparam logic [7:0] CMD_COPY         = 8'hE8;
    localparam logic [3:0] GRP_BIT_OP       = 4'hF;

    // mode set low three bits and character generator bit
    localparam logic [2:0] MODE_OR          = 3'h0;
    localparam logic [2:0] MODE_XOR         = 3'h1;
    localparam logic [2:0] MODE_AND         = 3'h3;
    localparam logic [2:0] MODE_ATTR        = 3'h4;
    localparam int         MODE_CG_BIT      = 3;

    // display mode bits
    localparam int         DISP_GRAPH_BIT   = 3;
    localparam int         DISP_TEXT_BIT    = 2;
    localparam int         DISP_CURSOR_BIT  = 1;
    localparam int         DISP_BLINK_BIT   = 0;

    // single data and bit commands
    localparam int         SD_READ_BIT      = 0;
    localparam logic [1:0] SD_PTR_INC       = 2'h0;
    localparam logic [1:0] SD_PTR_DEC       = 2'h1;
    localparam int         BIT_SET_BIT      = 3;

    // attribute low nibble
    localparam logic [3:0] ATTR_NORMAL      = 4'h0;
    localparam logic [3:0] ATTR_REVERSE     = 4'h5;
    localparam logic [3:0] ATTR_INHIBIT     = 4'h3;
    localparam int         ATTR_BLINK_BIT   = 3;

    // character generator split
    localparam logic [7:0] CG_EXT_FIRST     = 8'h80;

    // reset values and pointer step
    localparam logic [7:0]  RST_AREA        = 8'h00;
    localparam logic [15:0] RST_ADDR        = 16'h0000;
    localparam logic [2:0]  RST_CURSOR_N    = 3'h0;
    localparam logic [15:0] ADDR_STEP       = 16'h0001;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_OPER1 = 5'b00010,
        ST_OPER2 = 5'b00100,
        ST_AUTO  = 5'b01000,
        ST_RMW   = 5'b10000
    } lcc_state_t;

endpackage

// >>> design/lcc_attr_decode.sv
/*
 * Attribute byte decoder: low nibble to reverse, inhibit and blink.
 * Assumes the caller only looks at it while attribute mode is in use.
 */
`timescale 1ns/1ps
`default_nettype none
module lcc_attr_decode
    import lcc_pkg::*;
(
    input  wire logic [7:0] i_attr,
    output logic            o_reverse,
    output logic            o_inhibit,
    output logic            o_blink
);
    logic [3:0] nib;
    // upper nibble ignored; blink bit stands apart from the base style
    assign nib       = {1'b0, i_attr[2:0]};
    assign o_reverse = (nib == ATTR_REVERSE);
    assign o_inhibit = (nib == ATTR_INHIBIT);
    assign o_blink   = i_attr[ATTR_BLINK_BIT];
endmodule
`default_nettype wire

// >>> design/lcc_command_interp.sv
/*
 * Command interpreter of a graphic LCD controller. Takes command and data
 * bytes from the host port, keeps the display configuration, and runs
 * display RAM accesses through an address pointer.
 * Assumes a RAM port whose read data stands while the read strobe is
 * high, and a display engine that consumes the configuration outputs.
 */
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Contract
// - text area command sets bytes per text line, overriding hardware columns.
// - graphic area command sets bytes per graphic line.
// - mode low bits 000/001/011 pick OR, XOR, AND combine.
// - combine mode held until the next mode set command.
// - mode bit 3 picks character generator; codes 80H up always external (O_EXT_CG follows mode bit 3 alone, for every code).
// - attribute mode suppresses graphic; graphic byte acts as attribute.
// - attribute nibble gives normal, reverse, inhibit, blink; upper nibble ignored.
// - display mode bits: graphic, text, cursor, blink; zero turns off.
// - cursor pattern n gives n+1 raster lines, 1 to 8.
// - auto read or write moves pointer up one per byte.
// - in auto mode only auto reset is accepted.
// - single data commands read or write one byte, pointer up/down/kept.
// - screen peek places displayed byte at pointer into data stack.
// - peek outside graphic area is ignored and sets error flag.
// - screen copy writes one raster line into graphic area; not in attribute mode.
// - bit command sets or clears indexed bit of byte at pointer.
// - area commands take columns then zero operand.
// - set address pointer loads start address for RAM accesses.
module lcc_command_interp
    import lcc_pkg::*;
#(
    parameter int ADDR_W    = 16,
    parameter int HW_COLS   = 30,
    parameter int GRAPH_LINES = 128
) (
    input  wire logic              I_CLOCK,
    input  wire logic              I_RESET_N,
    input  wire logic              I_WR_STB,
    input  wire logic              I_RD_STB,
    input  wire logic              I_IS_CMD,
    input  wire logic [7:0]        I_DATA,
    input  wire logic [ADDR_W-1:0] I_GRAPH_HOME,
    input  wire logic [7:0]        I_RAM_RDATA,
    input  wire logic [7:0]        I_DISP_BYTE,
    output logic [7:0]             O_DATA,
    output logic                   O_DATA_VALID,
    output logic                   O_RAM_WE,
    output logic                   O_RAM_RE,
    output logic [ADDR_W-1:0]      O_RAM_ADDR,
    output logic [7:0]             O_RAM_WDATA,
    output logic [7:0]             O_TEXT_AREA,
    output logic [7:0]             O_GRAPH_AREA,
    output logic [2:0]             O_COMBINE_MODE,
    output logic                   O_EXT_CG,
    output logic                   O_ATTR_MODE,
    output logic                   O_GRAPH_ON,
    output logic                   O_TEXT_ON,
    output logic                   O_CURSOR_ON,
    output logic                   O_CURSOR_BLINK,
    output logic [3:0]             O_CURSOR_LINES,
    output logic                   O_AUTO_READ_READY,
    output logic                   O_AUTO_WRITE_READY,
    output logic                   O_PEEK_COPY_ERROR,
    output logic                   O_ATTR_REVERSE,
    output logic                   O_ATTR_INHIBIT,
    output logic                   O_ATTR_BLINK,
    output logic                   O_COPY_START
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic [ADDR_W-1:0] step_ptr(input logic [ADDR_W-1:0] p,
                                                   input logic [1:0] how);
        logic [ADDR_W-1:0] r;
        r = p;
        if (how == SD_PTR_INC) begin
            r = p + ADDR_W'(ADDR_STEP);
        end else if (how == SD_PTR_DEC) begin
            r = p - ADDR_W'(ADDR_STEP);
        end
        return r;
    endfunction

    function automatic logic in_graph_area(input logic [ADDR_W-1:0] p,
                                           input logic [ADDR_W-1:0] home,
                                           input logic [7:0] area);
        logic [ADDR_W+8:0] lim;
        lim = {9'h000, home} + ((ADDR_W+9)'(area) * (ADDR_W+9)'(GRAPH_LINES));
        return ({9'h000, p} >= {9'h000, home}) && ({9'h000, p} < lim);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    lcc_state_t        state_q;
    logic [7:0]        oper1_q;
    logic [7:0]        oper2_q;
    logic              auto_rd_q;
    logic              rmw_set_q;
    logic [2:0]        rmw_bit_q;
    logic              rd_pend_q;
    logic [ADDR_W-1:0] ram_address_pointer_q;
    logic [7:0]        text_area_q;
    logic [7:0]        graph_area_q;
    logic [3:0]        mode_q;
    logic [3:0]        disp_q;
    logic [2:0]        cursor_n_q;
    logic              peek_copy_error_flag_q;
    logic              copy_start_q;

    logic cmd_wr;
    logic data_wr;
    logic attr_rev;
    logic attr_inh;
    logic attr_blk;

    assign cmd_wr      = I_WR_STB && I_IS_CMD;
    assign data_wr     = I_WR_STB && !I_IS_CMD;

    ////////////////////////////////////////////////////////////////////////////
    // command sequencer

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_q   <= ST_IDLE;
            oper1_q   <= 8'h00;
            oper2_q   <= 8'h00;
            auto_rd_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (data_wr) begin
                        oper1_q <= I_DATA;
                        state_q <= ST_OPER1;
                    end else if (cmd_wr && (I_DATA == CMD_AUTO_WRITE
                                           || I_DATA == CMD_AUTO_READ)) begin
                        auto_rd_q <= I_DATA[0];
                        state_q   <= ST_AUTO;
                    end else if (cmd_wr && I_DATA[7:4] == GRP_BIT_OP) begin
                        state_q <= ST_RMW;
                    end
                end
                ST_OPER1: begin
                    // operands precede their command; a command ends the frame
                    if (data_wr) begin
                        oper2_q <= I_DATA;
                        state_q <= ST_OPER2;
                    end else if (cmd_wr) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_OPER2: begin
                    if (cmd_wr) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_AUTO: begin
                    // every other command is dropped here
                    if (cmd_wr && I_DATA == CMD_AUTO_RESET) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_RMW: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            text_area_q  <= 8'(HW_COLS);
            graph_area_q <= 8'(HW_COLS);
            mode_q       <= {1'b0, MODE_OR};
            disp_q       <= 4'h0;
            cursor_n_q   <= RST_CURSOR_N;
        end else if (cmd_wr && state_q != ST_AUTO) begin
            if (I_DATA == CMD_TEXT_AREA && state_q != ST_IDLE) begin
                text_area_q <= oper1_q;
            end
            if (I_DATA == CMD_GRAPH_AREA && state_q != ST_IDLE) begin
                graph_area_q <= oper1_q;
            end
            if (I_DATA[7:4] == GRP_MODE_SET) begin
                mode_q <= I_DATA[3:0];
            end
            if (I_DATA[7:4] == GRP_DISP_MODE) begin
                disp_q <= I_DATA[3:0];
            end
            if (I_DATA[7:3] == GRP_CURSOR_PAT) begin
                cursor_n_q <= I_DATA[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // address pointer and display RAM access

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ram_address_pointer_q  <= ADDR_W'(RST_ADDR);
            O_RAM_WE               <= 1'b0;
            O_RAM_RE               <= 1'b0;
            O_RAM_ADDR             <= ADDR_W'(RST_ADDR);
            O_RAM_WDATA            <= 8'h00;
            rd_pend_q              <= 1'b0;
            rmw_set_q              <= 1'b0;
            rmw_bit_q              <= 3'h0;
            peek_copy_error_flag_q <= 1'b0;
            copy_start_q           <= 1'b0;
            O_DATA                 <= 8'h00;
            O_DATA_VALID           <= 1'b0;
        end else begin
            O_RAM_WE     <= 1'b0;
            O_RAM_RE     <= 1'b0;
            O_DATA_VALID <= 1'b0;
            copy_start_q <= 1'b0;
            if (rd_pend_q) begin
                O_DATA       <= I_RAM_RDATA;
                O_DATA_VALID <= 1'b1;
                rd_pend_q    <= 1'b0;
            end
            if (state_q == ST_RMW) begin
                O_RAM_WE    <= 1'b1;
                O_RAM_ADDR  <= ram_address_pointer_q;
                O_RAM_WDATA <= rmw_set_q ? (I_RAM_RDATA | (8'h01 << rmw_bit_q))
                                         : (I_RAM_RDATA & ~(8'h01 << rmw_bit_q));
            end
            if (state_q == ST_AUTO) begin
                if (data_wr && !auto_rd_q) begin
                    O_RAM_WE              <= 1'b1;
                    O_RAM_ADDR            <= ram_address_pointer_q;
                    O_RAM_WDATA           <= I_DATA;
                    ram_address_pointer_q <= step_ptr(ram_address_pointer_q,
                                                      SD_PTR_INC);
                end else if (I_RD_STB && auto_rd_q && !rd_pend_q) begin
                    O_RAM_RE              <= 1'b1;
                    O_RAM_ADDR            <= ram_address_pointer_q;
                    rd_pend_q             <= 1'b1;
                    ram_address_pointer_q <= step_ptr(ram_address_pointer_q,
                                                      SD_PTR_INC);
                end
            end else if (cmd_wr) begin
                if (I_DATA == CMD_SET_ADDR_PTR && state_q == ST_OPER2) begin
                    ram_address_pointer_q <= ADDR_W'({oper2_q, oper1_q});
                end
                if (I_DATA[7:3] == GRP_SINGLE_DATA) begin
                    O_RAM_ADDR            <= ram_address_pointer_q;
                    ram_address_pointer_q <= step_ptr(ram_address_pointer_q,
                                                      I_DATA[2:1]);
                    if (I_DATA[SD_READ_BIT]) begin
                        O_RAM_RE  <= 1'b1;
                        rd_pend_q <= 1'b1;
                    end else if (state_q != ST_IDLE) begin
                        O_RAM_WE    <= 1'b1;
                        O_RAM_WDATA <= oper1_q;
                    end
                end
                if (I_DATA == CMD_PEEK) begin
                    if (in_graph_area(ram_address_pointer_q, I_GRAPH_HOME,
                                      graph_area_q)) begin
                        O_DATA                 <= I_DISP_BYTE;
                        O_DATA_VALID           <= 1'b1;
                        peek_copy_error_flag_q <= 1'b0;
                    end else begin
                        peek_copy_error_flag_q <= 1'b1;
                    end
                end
                if (I_DATA == CMD_COPY) begin
                    if (mode_q[2:0] == MODE_ATTR) begin
                        peek_copy_error_flag_q <= 1'b1;
                    end else begin
                        copy_start_q           <= 1'b1;
                        peek_copy_error_flag_q <= 1'b0;
                    end
                end
                if (I_DATA[7:4] == GRP_BIT_OP) begin
                    O_RAM_RE  <= 1'b1;
                    O_RAM_ADDR <= ram_address_pointer_q;
                    rmw_set_q <= I_DATA[BIT_SET_BIT];
                    rmw_bit_q <= I_DATA[2:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // attribute decode and registered outputs

    lcc_attr_decode u_attr (
        .i_attr    (I_DISP_BYTE),
        .o_reverse (attr_rev),
        .o_inhibit (attr_inh),
        .o_blink   (attr_blk)
    );

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_ATTR_REVERSE <= 1'b0;
            O_ATTR_INHIBIT <= 1'b0;
            O_ATTR_BLINK   <= 1'b0;
        end else begin
            O_ATTR_REVERSE <= attr_rev && (mode_q[2:0] == MODE_ATTR);
            O_ATTR_INHIBIT <= attr_inh && (mode_q[2:0] == MODE_ATTR);
            O_ATTR_BLINK   <= attr_blk && (mode_q[2:0] == MODE_ATTR);
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_TEXT_AREA        <= RST_AREA;
            O_GRAPH_AREA       <= RST_AREA;
            O_COMBINE_MODE     <= MODE_OR;
            O_EXT_CG           <= 1'b0;
            O_ATTR_MODE        <= 1'b0;
            O_GRAPH_ON         <= 1'b0;
            O_TEXT_ON          <= 1'b0;
            O_CURSOR_ON        <= 1'b0;
            O_CURSOR_BLINK     <= 1'b0;
            O_CURSOR_LINES     <= 4'h1;
            O_AUTO_READ_READY  <= 1'b0;
            O_AUTO_WRITE_READY <= 1'b0;
            O_PEEK_COPY_ERROR  <= 1'b0;
            O_COPY_START       <= 1'b0;
        end else begin
            O_TEXT_AREA        <= text_area_q;
            O_GRAPH_AREA       <= graph_area_q;
            O_COMBINE_MODE     <= mode_q[2:0];
            O_EXT_CG           <= mode_q[MODE_CG_BIT];
            O_ATTR_MODE        <= (mode_q[2:0] == MODE_ATTR);
            // attribute mode blanks graphic even with graphic enabled
            O_GRAPH_ON         <= disp_q[DISP_GRAPH_BIT]
                                  && (mode_q[2:0] != MODE_ATTR);
            O_TEXT_ON          <= disp_q[DISP_TEXT_BIT];
            O_CURSOR_ON        <= disp_q[DISP_CURSOR_BIT];
            O_CURSOR_BLINK     <= disp_q[DISP_BLINK_BIT];
            O_CURSOR_LINES     <= {1'b0, cursor_n_q} + 4'h1;
            O_AUTO_READ_READY  <= (state_q == ST_AUTO) && auto_rd_q
                                  && !rd_pend_q && !O_RAM_RE && !I_RD_STB;
            O_AUTO_WRITE_READY <= (state_q == ST_AUTO) && !auto_rd_q;
            O_PEEK_COPY_ERROR  <= peek_copy_error_flag_q;
            O_COPY_START       <= copy_start_q;
        end
    end

endmodule
`default_nettype wire

// >>> verif/lcc_command_interp_checker.sv
/* Checker on the interpreter's host and configuration ports.
   Assumes the host keeps operand-then-command order and idles after bit commands. */
`timescale 1ns/1ps
`default_nettype none
module lcc_command_interp_checker
    import lcc_pkg::*;
(
    input wire logic       I_CLOCK,
    input wire logic       I_RESET_N,
    input wire logic       I_WR_STB,
    input wire logic       I_IS_CMD,
    input wire logic [7:0] I_DATA,
    input wire logic       O_RAM_WE,
    input wire logic [7:0] O_RAM_WDATA,
    input wire logic [7:0] O_TEXT_AREA,
    input wire logic [2:0] O_COMBINE_MODE,
    input wire logic       O_EXT_CG,
    input wire logic       O_TEXT_ON,
    input wire logic [3:0] O_CURSOR_LINES,
    input wire logic       O_AUTO_WRITE_READY
);
    logic       auto_q;
    logic       aw_q;
    logic [7:0] opnd_q;
    logic [7:0] opnd_p;
    wire        hcmd = I_WR_STB && I_IS_CMD;
    wire        cmd  = hcmd && !auto_q;
    wire        mset = cmd && I_DATA[7:4] == GRP_MODE_SET;
    // auto mode tracked here so refused commands never arm a property
    always_ff @(posedge I_CLOCK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            auto_q <= 1'b0;
            aw_q   <= 1'b0;
        end else if (hcmd && (I_DATA == CMD_AUTO_RESET || !auto_q && I_DATA[7:1] == 7'h58)) begin
            auto_q <= I_DATA != CMD_AUTO_RESET;
            aw_q   <= I_DATA == CMD_AUTO_WRITE;
        end
    end
    always_ff @(posedge I_CLOCK) begin
        if (I_WR_STB && !I_IS_CMD) begin
            opnd_q <= I_DATA;
            opnd_p <= opnd_q;
        end
    end
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RESET_N);
    ////////////////////////////////////////////////////////////
    property p_area;
        cmd && I_DATA == CMD_TEXT_AREA |-> ##2 O_TEXT_AREA == $past(opnd_p, 2); endproperty
    a_area: assert property (p_area) else $error("text area not loaded");
    property p_mode;
        mset |-> ##2 O_COMBINE_MODE == $past(I_DATA[2:0], 2) && O_EXT_CG == $past(I_DATA[3], 2); endproperty
    a_mode: assert property (p_mode) else $error("mode set not applied");
    property p_hold;
        $changed(O_COMBINE_MODE) |-> $past(mset, 2); endproperty
    a_hold: assert property (p_hold) else $error("combine mode moved alone");
    property p_curs;
        cmd && I_DATA[7:3] == GRP_CURSOR_PAT |-> ##2 O_CURSOR_LINES == {1'b0, $past(I_DATA[2:0], 2)} + 4'h1; endproperty
    a_curs: assert property (p_curs) else $error("cursor height wrong");
    property p_refuse;
        auto_q |-> ##2 $stable({O_TEXT_ON, O_CURSOR_LINES, O_COMBINE_MODE}); endproperty
    a_refuse: assert property (p_refuse) else $error("command run in auto mode");
    property p_autow;
        aw_q && I_WR_STB && !I_IS_CMD |=> O_RAM_WE && O_RAM_WDATA == $past(I_DATA); endproperty
    a_autow: assert property (p_autow) else $error("auto byte not written");
    property p_ready;
        $rose(aw_q) |-> ##[0:2] O_AUTO_WRITE_READY; endproperty
    a_ready: assert property (p_ready) else $error("auto write ready late");
    property p_single;
        cmd && I_DATA[7:3] == GRP_SINGLE_DATA && !I_DATA[0] |=> O_RAM_WE && O_RAM_WDATA == $past(opnd_q); endproperty
    a_single: assert property (p_single) else $error("single write missing");
endmodule
bind lcc_command_interp lcc_command_interp_checker u_chk (.*);
`default_nettype wire

// >>> verif/lcc_ram_model.sv
/* Display RAM standing behind the interpreter's RAM port.
   Assumes reads are sampled at the edge that ends the read strobe. */
`timescale 1ns/1ps
`default_nettype none
module lcc_ram_model (
    input  wire logic        i_clk,
    input  wire logic        i_we,
    input  wire logic        i_re,
    input  wire logic [15:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    output logic [7:0]       o_rdata
);
    logic [7:0] mem [0:65535];
    logic [7:0] last_q = 8'h00;
    // no pull on read data: idle shows the inverse of the last byte read
    always @(posedge i_clk) begin
        if (i_we) mem[i_addr] <= i_wdata;
        if (i_re) last_q <= mem[i_addr];
    end
    assign o_rdata = i_re ? mem[i_addr] : ~last_q;
endmodule
`default_nettype wire

// >>> verif/tb_lcd_controller_command_set.sv
/* Self-checking bench for the command interpreter.
   Assumes the display RAM model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_controller_command_set
    import lcc_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, cm = 1'b0;
    logic [7:0]  dat = 8'h00, disp = 8'h00, odat, ta, ga, wd, rdt;
    logic [15:0] ra;
    logic [2:0]  cmod;
    logic [3:0]  cl;
    logic        dv, we, re, ecg, att, gon, ton, con, cbl, arr, awr, perr, rev, inh, blk, cst;
    int          mismatches = 0, total_checks = 0;
    always #50 clk = ~clk;
    lcc_command_interp #(.GRAPH_LINES(4)) DUT (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_WR_STB(wr),
        .I_RD_STB(rd), .I_IS_CMD(cm), .I_DATA(dat), .I_GRAPH_HOME(16'h1000), .I_RAM_RDATA(rdt),
        .I_DISP_BYTE(disp), .O_DATA(odat), .O_DATA_VALID(dv), .O_RAM_WE(we), .O_RAM_RE(re),
        .O_RAM_ADDR(ra), .O_RAM_WDATA(wd), .O_TEXT_AREA(ta), .O_GRAPH_AREA(ga),
        .O_COMBINE_MODE(cmod), .O_EXT_CG(ecg), .O_ATTR_MODE(att), .O_GRAPH_ON(gon),
        .O_TEXT_ON(ton), .O_CURSOR_ON(con), .O_CURSOR_BLINK(cbl), .O_CURSOR_LINES(cl),
        .O_AUTO_READ_READY(arr), .O_AUTO_WRITE_READY(awr), .O_PEEK_COPY_ERROR(perr),
        .O_ATTR_REVERSE(rev), .O_ATTR_INHIBIT(inh), .O_ATTR_BLINK(blk), .O_COPY_START(cst));
    lcc_ram_model u_ram (.i_clk(clk), .i_we(we), .i_re(re), .i_addr(ra), .i_wdata(wd), .o_rdata(rdt));
    ////////////////////////////////////////////////////////////
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // idle edge first, so a strobe is never lowered and raised in one step
    task automatic put(input logic c, input logic [7:0] d);
        tick(1);
        {wr, cm, dat} = {1'b1, c, d};
        tick(1);
        wr = 1'b0;
    endtask
    task automatic sendq(input logic [8:0] q [$]);
        foreach (q[i]) put(q[i][8], q[i][7:0]);
    endtask
    task automatic await(input string nm, ref logic s);
        int n = 0;
        while (s !== 1'b1 && n < 20) begin
            tick(1);
            n++;
        end
        if (s !== 1'b1) begin
            chk(nm, 16'hDEAD, 16'h0001);
            test_done();
        end
    endtask
    task automatic rdchk(input logic [7:0] c, input logic [7:0] e);
        put(1'b1, c);
        await("valid", dv);
        chk("read data", odat, e);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_cfg;
        logic [2:0] m [3] = '{MODE_OR, MODE_XOR, MODE_AND};
        tick(1);
        chk("reset area", ta, 16'h001E);
        chk("reset cursor", cl, 16'h0001);
        sendq('{9'h020, 9'h000, 9'h141, 9'h014, 9'h000, 9'h143});
        tick(2);
        chk("text area", ta, 16'h0020);
        chk("graph area", ga, 16'h0014);
        for (int i = 0; i < 3; i++) begin
            put(1'b1, {GRP_MODE_SET, i[0], m[i]});
            tick(4);
            chk("combine", cmod, m[i]);
            chk("ext cg", ecg, i[0]);
        end
        for (int n = 0; n < 8; n++) begin
            put(1'b1, {GRP_CURSOR_PAT, n[2:0]});
            tick(2);
            chk("cursor lines", cl, 16'(n + 1));
        end
        for (int v = 0; v < 16; v++) begin
            put(1'b1, {GRP_DISP_MODE, v[3:0]});
            tick(2);
            chk("display", {gon, ton, con, cbl}, 16'(v[3:0]));
        end
        $display("t_cfg done");
    endtask
    task automatic t_attr;
        logic [3:0] ac [6] = '{4'h0, 4'h5, 4'h3, 4'h8, 4'hD, 4'hB};
        logic [2:0] ex [6] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h5, 3'h3};
        sendq('{9'h19C, 9'h184});
        tick(2);
        chk("graph off", {att, gon}, 16'h0002);
        foreach (ac[i]) begin
            disp = {4'hF, ac[i]};
            tick(3);
            chk("attribute", {rev, inh, blk}, ex[i]);
        end
        put(1'b1, CMD_COPY);
        tick(3);
        chk("copy refused", perr, 16'h0001);
        put(1'b1, 8'h80);
        $display("t_attr done");
    endtask
    task automatic t_ram;
        sendq('{9'h000, 9'h001, 9'h124, 9'h0A5, 9'h1C0, 9'h05A, 9'h1C4, 9'h03C, 9'h1C2});
        rdchk(8'hC5, 8'hA5);
        rdchk(8'hC1, 8'hA5);
        rdchk(8'hC3, 8'h3C);
        put(1'b1, 8'hFB);
        tick(2);
        put(1'b1, 8'hF0);
        tick(2);
        put(1'b1, 8'hF7);
        tick(2);
        chk("bit ops", u_ram.mem[16'h0100], 16'h002C);
        $display("t_ram done");
    endtask
    task automatic t_auto;
        sendq('{9'h000, 9'h002, 9'h124, 9'h1B0});
        for (int i = 0; i < 3; i++) begin
            await("write ready", awr);
            put(1'b0, 8'(8'h10 + i));
        end
        put(1'b1, 8'h90);
        await("write ready", awr);
        put(1'b1, CMD_AUTO_RESET);
        tick(2);
        chk("refused", ton, 16'h0001);
        chk("auto bytes", u_ram.mem[16'h0202], 16'h0012);
        sendq('{9'h000, 9'h002, 9'h124, 9'h1B1});
        for (int i = 0; i < 3; i++) begin
            await("read ready", arr);
            tick(1);
            rd = 1'b1;
            tick(1);
            rd = 1'b0;
            await("valid", dv);
            chk("auto read", odat, 16'(8'h10 + i));
        end
        await("read ready", arr);
        put(1'b1, CMD_AUTO_RESET);
        $display("t_auto done");
    endtask
    task automatic t_peek;
        disp = 8'h3C;
        sendq('{9'h001, 9'h010, 9'h124});
        rdchk(CMD_PEEK, 8'h3C);
        tick(2);
        chk("peek ok", perr, 16'h0000);
        sendq('{9'h000, 9'h001, 9'h124, 9'h1E0});
        tick(2);
        chk("peek error", perr, 16'h0001);
        put(1'b1, CMD_COPY);
        await("copy start", cst);
        $display("t_peek done");
    endtask
    initial begin
        tick(3);
        rst_n = 1'b1;
        t_cfg();
        t_attr();
        t_ram();
        t_auto();
        t_peek();
        test_done();
    end
endmodule
`default_nettype wire
